/* File: rtesc_dev.sv */
`timescale 1ns/1ps
module rtesc_dev
   import rtesc_pkg::*;
#(
   parameter int DWELL_CYC = 20,
   parameter int ACK_DLY   = 5
) (
   input  wire logic                   i_clk_sys,
   input  wire logic                   i_rst,
   input  wire logic                   i_mute,
   input  wire logic [8*IMG_BYTES-1:0] i_img_out,
   output logic [8*IMG_BYTES-1:0]      o_img_in
);
   logic        req_q;
   logic        busy_q;
   int          cnt_q;
   logic [7:0]  noise_q;
   logic [63:0] res_q;
   logic [7:0]  stat;

   // Nibble per channel, 0 to 0xf
   function automatic logic [63:0] scan_result();
      logic [63:0] r;
      r = '0;
      for (int k = 0; k < CH_COUNT; k++) begin
         r[8*(k/2)+4*(1-k%2) +: 4] = 4'(5*k+3);
      end
      return r;
   endfunction

   // Ack, dwell per channel, then drop
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         req_q   <= 1'b0;
         busy_q  <= 1'b0;
         cnt_q   <= 0;
         res_q   <= '0;
         noise_q <= 8'h00;
      end else begin
         req_q   <= i_img_out[BIT_ENERGY_SCAN];
         noise_q <= noise_q + 8'h3b;
         if (cnt_q == 0 && !i_mute && i_img_out[BIT_ENERGY_SCAN] && !req_q) begin
            cnt_q <= 1;
         end else if (cnt_q == ACK_DLY + CH_COUNT*DWELL_CYC) begin
            cnt_q  <= 0;
            busy_q <= 1'b0;
            res_q  <= scan_result();
         end else if (cnt_q != 0) begin
            cnt_q <= cnt_q + 1;
            if (cnt_q == ACK_DLY) begin
               busy_q <= 1'b1;
            end
         end
      end
   end

   assign stat = {i_img_out[7], 1'b0, i_img_out[5:2], busy_q, i_img_out[0]};
   // Trailing bytes carry noise, results garbled mid-scan
   assign o_img_in = {~{noise_q, noise_q}, busy_q ? ~res_q : res_q, 8'h00, stat};
endmodule

/* File: rtesc_host.sv */
// Chosen here: the strobed register port and the register addresses.
`timescale 1ns/1ps
module rtesc_host
   import rtesc_pkg::*;
#(
   parameter longint ACK_WAIT_CYC = 64'd4000,
   parameter longint SCAN_TIMEOUT = SCAN_LIMIT_CYC,
   parameter int     CFG_CYC      = 16
) (
   input  wire logic                i_clk_sys,
   input  wire logic                i_rst,
   input  wire rtesc_bus_t          i_bus,
   output logic [31:0]              o_rdata,
   output logic                     o_irq,
   input  wire logic [8*IMG_BYTES-1:0] i_img_in,
   output logic [8*IMG_BYTES-1:0]   o_img_out,
   output logic [3:0]               o_radio_channel_select,
   output logic                     o_broadcast_master_select,
   output logic [15:0]              o_slave_watchdog_time,
   output logic                     o_config_done
);
   initial begin
      if (ACK_WAIT_CYC < 1 || SCAN_TIMEOUT <= ACK_WAIT_CYC || CFG_CYC < 1) begin
         $error("rtesc_host: bad timing parameters");
      end
   end

   rtesc_state_t        state_q;
   logic [39:0]         cnt_q;
   logic                ctl_scan_q;
   logic [7:0]          ctrl_byte_q;
   logic [63:0]         result_q;
   logic [3:0]          irq_stat_q;
   logic [3:0]          irq_mask_q;
   logic [3:0]          chan_q;
   logic                bcast_q;
   logic                master_q;
   logic [15:0]         wdog_q;
   logic                cfg_done_q;
   logic [3:0]          ev;
   logic [7:0]          status_byte;
   logic                dev_scanning;
   logic                wr_ctrl;

   // Status byte one is the first input image byte
   assign status_byte  = i_img_in[7:0];
   assign dev_scanning = status_byte[BIT_ENERGY_SCAN];
   assign wr_ctrl      = i_bus.wr && i_bus.addr == ADR_CTRL;

   // Scan sequencer and configuration transfer
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         state_q     <= RTESC_IDLE;
         cnt_q       <= '0;
         ctrl_byte_q <= 8'h00;
         result_q    <= '0;
         cfg_done_q  <= 1'b0;
         ev          <= 4'h0;
      end else begin
         ev  <= 4'h0;
         cnt_q <= cnt_q + 40'd1;
         unique case (state_q)
            RTESC_IDLE: begin
               cnt_q <= '0;
               if (wr_ctrl && i_bus.wdata[CTL_SCAN_GO]) begin
                  state_q <= RTESC_REQ;
               end else if (wr_ctrl && i_bus.wdata[CTL_CFG_GO]) begin
                  cfg_done_q <= 1'b0;
                  state_q    <= RTESC_CFG;
               end
            end
            RTESC_REQ: begin
               ctrl_byte_q[BIT_ENERGY_SCAN] <= 1'b1;
               cnt_q   <= '0;
               state_q <= RTESC_WAIT_ACK;
            end
            RTESC_WAIT_ACK: begin
               if (dev_scanning) begin
                  state_q <= RTESC_RUN;
               end else if (cnt_q >= 40'(ACK_WAIT_CYC)) begin
                  ev[IRQ_SCAN_ERR] <= 1'b1;
                  state_q <= RTESC_RELEASE;
               end
            end
            RTESC_RUN: begin
               if (!dev_scanning) begin
                  // Keep bytes 2 to 9 only
                  result_q <= i_img_in[8*(RES_BYTES+2)-1:16];
                  ev[IRQ_SCAN_DONE] <= 1'b1;
                  state_q <= RTESC_RELEASE;
               end else if (cnt_q >= 40'(SCAN_TIMEOUT)) begin
                  ev[IRQ_SCAN_ERR] <= 1'b1;
                  state_q <= RTESC_RELEASE;
               end
            end
            RTESC_RELEASE: begin
               // Drop request before any new one
               ctrl_byte_q[BIT_ENERGY_SCAN] <= 1'b0;
               if (!dev_scanning) begin
                  state_q <= RTESC_IDLE;
               end
            end
            RTESC_CFG: begin
               if (cnt_q >= 40'(CFG_CYC)) begin
                  cfg_done_q <= 1'b1;
                  ev[IRQ_CFG_DONE] <= 1'b1;
                  state_q <= RTESC_IDLE;
               end
            end
         endcase
         if (wr_ctrl && (i_bus.addr == ADR_CTRL) && i_bus.wdata[CTL_BCAST] &&
             !i_bus.wdata[CTL_MASTER]) begin
            ev[IRQ_BAD_ARG] <= 1'b1;
         end
      end
   end

   // Slave count, payload
   // Exchange handlers and payloads stay with software; none are issued here

   // Configuration settings
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         chan_q   <= 4'h0;
         bcast_q  <= 1'b0;
         master_q <= 1'b0;
         wdog_q   <= 16'h0000;
         ctl_scan_q <= 1'b0;
      end else begin
         ctl_scan_q <= state_q != RTESC_IDLE && state_q != RTESC_CFG;
         if (wr_ctrl) begin
            master_q <= i_bus.wdata[CTL_MASTER];
            bcast_q  <= i_bus.wdata[CTL_BCAST] & i_bus.wdata[CTL_MASTER];
         end
         // Channel limited to 0..15 by width
         if (i_bus.wr && i_bus.addr == ADR_CHAN) begin
            chan_q <= i_bus.wdata[3:0];
         end
         if (i_bus.wr && i_bus.addr == ADR_WDOG) begin
            wdog_q <= i_bus.wdata[15:0];
         end
      end
   end

   // Interrupt status, set wins over write-one clear
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         irq_stat_q <= IRQ_RESET;
         irq_mask_q <= IRQ_RESET;
      end else begin
         if (i_bus.wr && i_bus.addr == ADR_IRQ_STAT) begin
            irq_stat_q <= (irq_stat_q & ~i_bus.wdata[3:0]) | ev;
         end else begin
            irq_stat_q <= irq_stat_q | ev;
         end
         if (i_bus.wr && i_bus.addr == ADR_IRQ_MASK) begin
            irq_mask_q <= i_bus.wdata[3:0];
         end
      end
   end

   // Register read port and outputs
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         o_rdata   <= 32'h0000_0000;
         o_irq     <= 1'b0;
         o_img_out <= '0;
         o_radio_channel_select    <= 4'h0;
         o_broadcast_master_select <= 1'b0;
         o_slave_watchdog_time     <= 16'h0000;
         o_config_done             <= 1'b0;
      end else begin
         o_irq <= |(irq_stat_q & irq_mask_q);
         // Control byte one in image byte 0
         o_img_out <= {{(8*IMG_BYTES-8){1'b0}}, ctrl_byte_q};
         o_radio_channel_select    <= chan_q;
         o_broadcast_master_select <= bcast_q;
         o_slave_watchdog_time     <= master_q ? 16'h0000 : wdog_q;
         o_config_done             <= cfg_done_q;
         o_rdata <= 32'h0000_0000;
         if (i_bus.rd) begin
            unique case (i_bus.addr)
               ADR_CTRL:     o_rdata <= {28'h0, master_q, bcast_q, cfg_done_q, ctl_scan_q};
               ADR_STATUS:   o_rdata <= {24'h0, 5'(state_q), 3'h0};
               ADR_IRQ_STAT: o_rdata <= {28'h0, irq_stat_q};
               ADR_IRQ_MASK: o_rdata <= {28'h0, irq_mask_q};
               ADR_CHAN:     o_rdata <= {28'h0, chan_q};
               ADR_WDOG:     o_rdata <= {16'h0, wdog_q};
               ADR_RES_LO:   o_rdata <= result_q[31:0];
               ADR_RES_HI:   o_rdata <= result_q[63:32];
               ADR_DEV_STAT: o_rdata <= {24'h0, status_byte};
               default:      o_rdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   a_req_raised: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      state_q == RTESC_REQ |=> ctrl_byte_q[BIT_ENERGY_SCAN])
      else $error("scan request not raised");
   a_done_event: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      state_q == RTESC_RUN && !dev_scanning |=> ev[IRQ_SCAN_DONE] ##1
      irq_stat_q[IRQ_SCAN_DONE])
      else $error("scan done not flagged");
   a_result_bytes: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      state_q == RTESC_RUN && !dev_scanning |=> result_q == $past(i_img_in[79:16]))
      else $error("wrong result bytes");
   a_req_drop: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      state_q == RTESC_RELEASE |=> !ctrl_byte_q[BIT_ENERGY_SCAN])
      else $error("request not dropped");
   a_bcast_master: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      bcast_q |-> master_q)
      else $error("broadcast without master");
   a_wdog_slave: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      master_q |=> o_slave_watchdog_time == 16'h0000)
      else $error("watchdog driven as master");
   a_cfg_done: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      $rose(cfg_done_q) |-> $past(state_q) == RTESC_CFG)
      else $error("config done early");
   a_ack_run: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      state_q == RTESC_WAIT_ACK && dev_scanning |=> state_q == RTESC_RUN)
      else $error("acknowledge missed");
   a_irq_level: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      |(irq_stat_q & irq_mask_q) |=> o_irq)
      else $error("irq not raised");
   // Masked events keep interrupt low
   a_irq_quiet: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      !(|(irq_stat_q & irq_mask_q)) |=> !o_irq)
      else $error("irq raised while masked");
   // Read data only after a read
   a_rdata_quiet: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      !i_bus.rd |=> o_rdata == 32'h0000_0000)
      else $error("read data without read");
   a_ack_timeout: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      state_q == RTESC_WAIT_ACK && !dev_scanning && cnt_q >= 40'(ACK_WAIT_CYC)
      |=> state_q == RTESC_RELEASE && ev[IRQ_SCAN_ERR])
      else $error("acknowledge timeout missed");
   a_scan_limit: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      state_q == RTESC_RUN && dev_scanning && cnt_q >= 40'(SCAN_TIMEOUT) |=> ev[IRQ_SCAN_ERR])
      else $error("scan overrun missed");
   a_bad_arg: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      wr_ctrl && i_bus.wdata[CTL_BCAST] && !i_bus.wdata[CTL_MASTER] |=> ev[IRQ_BAD_ARG])
      else $error("bad broadcast order not flagged");
   a_img_ctrl: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      1'b1 |=> o_img_out[7:0] == $past(ctrl_byte_q))
      else $error("control byte not in image");
   a_req_hold: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      state_q == RTESC_RUN |-> ctrl_byte_q[BIT_ENERGY_SCAN])
      else $error("request lost during scan");
   a_req_fresh: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      state_q == RTESC_IDLE && wr_ctrl && i_bus.wdata[CTL_SCAN_GO]
      |-> !ctrl_byte_q[BIT_ENERGY_SCAN])
      else $error("request still set at new order");
   a_chan_out: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      1'b1 |=> o_radio_channel_select == $past(chan_q))
      else $error("channel not driven");
   a_cfg_busy: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      state_q == RTESC_CFG |-> !cfg_done_q)
      else $error("config done during transfer");
   a_cfg_event: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      $rose(cfg_done_q) |-> ev[IRQ_CFG_DONE])
      else $error("config done event missing");

   c_scan_done: cover property (@(posedge i_clk_sys) ev[IRQ_SCAN_DONE]);
   c_scan_err:  cover property (@(posedge i_clk_sys) ev[IRQ_SCAN_ERR]);
   c_cfg_done:  cover property (@(posedge i_clk_sys) ev[IRQ_CFG_DONE]);
   c_bad_arg:   cover property (@(posedge i_clk_sys) ev[IRQ_BAD_ARG]);
   c_ack_seen:  cover property (@(posedge i_clk_sys) state_q == RTESC_RUN);
endmodule

/* File: rtesc_host_tb_top.sv */
`timescale 1ns/1ps
module rtesc_host_tb_top
   import rtesc_pkg::*;
;
   logic                   i_clk_sys, i_rst, mute, irq, cfg_done, bcast, req_bit;
   rtesc_bus_t             bus;
   logic [31:0]            rdata, rd_v;
   logic [8*IMG_BYTES-1:0] img_in, img_out;
   logic [3:0]             chan;
   logic [15:0]            wdog;
   logic [63:0]            exp_res;
   int                     error_cnt, checks, n;

   rtesc_host #(.ACK_WAIT_CYC(64'd50), .SCAN_TIMEOUT(64'd2000), .CFG_CYC(16)) rtesc_host_i (
      .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_bus(bus), .o_rdata(rdata), .o_irq(irq),
      .i_img_in(img_in), .o_img_out(img_out), .o_radio_channel_select(chan),
      .o_broadcast_master_select(bcast), .o_slave_watchdog_time(wdog),
      .o_config_done(cfg_done));
   rtesc_dev #(.DWELL_CYC(20), .ACK_DLY(5)) rtesc_dev_i (
      .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_mute(mute), .i_img_out(img_out),
      .o_img_in(img_in));

   always_comb req_bit = img_out[BIT_ENERGY_SCAN];

   initial begin
      i_clk_sys = 1'b0;
      forever #2.5 i_clk_sys = ~i_clk_sys;
   end

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic bwr(input logic [3:0] a, input logic [31:0] d);
      @(posedge i_clk_sys);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge i_clk_sys);
      bus.wr <= 1'b0;
   endtask

   task automatic rchk(input string nm, input logic [3:0] a, input logic [31:0] e);
      @(posedge i_clk_sys);
      bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
      @(posedge i_clk_sys);
      bus.rd <= 1'b0;
      #1 rd_v = rdata;
      chk(nm, e, rd_v);
   endtask

   task automatic wt(ref logic s, input logic v, input int lim, input string nm);
      for (n = 0; n < lim && s !== v; n++) @(posedge i_clk_sys);
      #1 chk(nm, {31'h0, v}, {31'h0, s});
   endtask

   task automatic t_reset();
      rchk("ctrl", ADR_CTRL, 32'h0);
      rchk("irq_stat", ADR_IRQ_STAT, 32'h0);
      rchk("irq_mask", ADR_IRQ_MASK, 32'h0);
      rchk("unmapped", 4'hf, 32'h0);
      chk("ctrl byte", 32'h0, {24'h0, img_out[7:0]});
      $display("test reset done");
   endtask

   task automatic t_scan();
      for (int k = 0; k < CH_COUNT; k++) exp_res[8*(k/2)+4*(1-k%2) +: 4] = 4'(5*k+3);
      bwr(ADR_IRQ_MASK, 32'h1);
      bwr(ADR_CTRL, 32'h1);
      wt(req_bit, 1'b1, 8, "scan request");
      chk("ctrl byte", 32'h02, {24'h0, img_out[7:0]});
      rchk("scan busy", ADR_CTRL, 32'h1);
      chk("irq early", 32'h0, {31'h0, irq});
      wt(irq, 1'b1, 400, "scan irq");
      chk("scan length", 32'h1, 32'(n >= 300));
      chk("request drop", 32'h0, {31'h0, req_bit});
      rchk("res lo", ADR_RES_LO, exp_res[31:0]);
      rchk("res hi", ADR_RES_HI, exp_res[63:32]);
      rchk("dev stat", ADR_DEV_STAT, 32'h0);
      rchk("irq_stat", ADR_IRQ_STAT, 32'h1);
      bwr(ADR_IRQ_STAT, 32'h1);
      wt(irq, 1'b0, 4, "irq clear");
      $display("test scan done");
   endtask

   task automatic t_timeout();
      @(posedge i_clk_sys);
      mute <= 1'b1;
      bwr(ADR_CTRL, 32'h1);
      wt(req_bit, 1'b1, 8, "scan request");
      repeat (80) @(posedge i_clk_sys);
      rchk("irq_stat", ADR_IRQ_STAT, 32'h2);
      chk("masked irq", 32'h0, {31'h0, irq});
      bwr(ADR_IRQ_STAT, 32'h2);
      mute <= 1'b0;
      rchk("idle", ADR_STATUS, 32'h0);
      $display("test timeout done");
   endtask

   task automatic t_cfg();
      bwr(ADR_IRQ_MASK, 32'hc);
      bwr(ADR_CHAN, 32'h9);
      bwr(ADR_WDOG, 32'h1234);
      bwr(ADR_CTRL, 32'he);
      wt(cfg_done, 1'b1, 40, "config done");
      chk("channel", 32'h9, {28'h0, chan});
      rchk("chan reg", ADR_CHAN, 32'h9);
      chk("bcast master", 32'h1, {31'h0, bcast});
      chk("wdog master", 32'h0, {16'h0, wdog});
      rchk("wdog reg", ADR_WDOG, 32'h1234);
      wt(irq, 1'b1, 4, "cfg irq");
      rchk("irq_stat", ADR_IRQ_STAT, 32'h4);
      bwr(ADR_IRQ_STAT, 32'h4);
      bwr(ADR_CTRL, 32'h6);
      repeat (40) @(posedge i_clk_sys);
      rchk("irq_stat", ADR_IRQ_STAT, 32'hc);
      chk("bcast slave", 32'h0, {31'h0, bcast});
      chk("wdog slave", 32'h1234, {16'h0, wdog});
      $display("test config done");
   endtask

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge i_clk_sys);
      error_cnt++;
      end_of_test();
   end

   initial begin
      bus = '0;
      mute = 1'b0;
      i_rst = 1'b1;
      error_cnt = 0;
      checks = 0;
      repeat (8) @(posedge i_clk_sys);
      i_rst <= 1'b0;
      t_reset();
      t_scan();
      t_timeout();
      t_cfg();
      end_of_test();
   end
endmodule

/* File: rtesc_pkg.sv */
// Summary of operation
// - Host requests a scan by setting control byte one bit 1.
// - Falling status bit 1 marks scan results valid for the host.
// - Host ignores input data bytes 10 and 11 after a scan.
// - Control byte one: access, error, address, scan, energy scan, start.
// - Host selects radio channel only from 0 to 15.
// - Broadcast master only applies in master mode; never requested as slave.
// - Slave watchdog time applies only in slave mode.
// - Host serves at most seven slaves.
// - Host limits each payload to at most 10 bytes.
// - Host finishes configuration before any master-slave exchange.
package rtesc_pkg;
   localparam int          IMG_BYTES       = 12;
   localparam int          RES_BYTES       = 8;
   localparam int          CH_COUNT        = 16;
   localparam int          BIT_REG_ACCESS  = 7;
   localparam int          BIT_ERROR       = 6;
   localparam int          BIT_ADDR_LO     = 3;
   localparam int          BIT_SCAN        = 2;
   localparam int          BIT_ENERGY_SCAN = 1;
   localparam int          BIT_START       = 0;
   localparam int          MAX_CHANNEL     = 15;
   localparam int          MAX_SLAVES      = 7;
   localparam int          MAX_PAYLOAD     = 10;
   localparam int          CLK_MHZ         = 200;
   localparam int          CH_DWELL_S      = 5;
   localparam int          SCAN_TOTAL_S    = 80;
   localparam longint      SCAN_TOTAL_CYC  = 64'(SCAN_TOTAL_S) * CLK_MHZ * 1000000;
   localparam int          SLACK_S         = 40;
   localparam longint      SCAN_LIMIT_CYC  = 64'(SCAN_TOTAL_S + SLACK_S) * CLK_MHZ * 1000000;
   localparam logic [3:0]  ADR_CTRL        = 4'h0;
   localparam logic [3:0]  ADR_STATUS      = 4'h1;
   localparam logic [3:0]  ADR_IRQ_STAT    = 4'h2;
   localparam logic [3:0]  ADR_IRQ_MASK    = 4'h3;
   localparam logic [3:0]  ADR_CHAN        = 4'h4;
   localparam logic [3:0]  ADR_WDOG        = 4'h5;
   localparam logic [3:0]  ADR_RES_LO      = 4'h6;
   localparam logic [3:0]  ADR_RES_HI      = 4'h7;
   localparam logic [3:0]  ADR_DEV_STAT    = 4'h8;
   localparam int          CTL_SCAN_GO     = 0;
   localparam int          CTL_CFG_GO      = 1;
   localparam int          CTL_BCAST       = 2;
   localparam int          CTL_MASTER      = 3;
   localparam int          IRQ_SCAN_DONE   = 0;
   localparam int          IRQ_SCAN_ERR    = 1;
   localparam int          IRQ_CFG_DONE    = 2;
   localparam int          IRQ_BAD_ARG     = 3;
   localparam logic [3:0]  IRQ_RESET       = 4'h0;

   typedef struct packed {
      logic [3:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } rtesc_bus_t;

   typedef enum logic [2:0] {
      RTESC_IDLE, RTESC_REQ, RTESC_WAIT_ACK, RTESC_RUN, RTESC_RELEASE, RTESC_CFG
   } rtesc_state_t;
endpackage
